// ==== verilog/pss_status_summary.sv ====
`timescale 1ns/10ps
module pss_status_summary
  import pss_pkg::*;
(
  input  wire logic              ref_clk,      // System clock, 100 MHz.
  input  wire logic              rst,          // Synchronous reset, active high.
  input  wire pss_bus_req_t      bus_req,      // Management bus request.
  output logic [`PSS_DATA_W-1:0] rd_data,      // Read data, cycle after the read.
  input  wire pss_phy_in_t       phy_in,       // Raw physical-layer indications.
  output logic                   sd_qual_q     // Qualified signal detect to link monitor.
);

  logic [`PSS_DATA_W-1:0]   summary_w;
  logic [`PSS_NUM_LATCH-1:0] latch_set;
  logic [`PSS_NUM_LATCH-1:0] latch_clr;
  logic [`PSS_NUM_LATCH-1:0] latch_q;
  logic                     sd_qual_en;
  logic                     sd_qual_d;
  pss_rd_hit_t              rd_hit;
  logic                     rst_q;

  pss_reg_port u_reg_port (
    .ref_clk    (ref_clk),
    .bus_req    (bus_req),
    .rst        (rst),
    .summary_w  (summary_w),
    .rd_data    (rd_data),
    .sd_qual_en (sd_qual_en),
    .rd_hit     (rd_hit)
  );

  assign sd_qual_d = phy_in.signal_detect_raw & (phy_in.descrambler_lock | ~sd_qual_en);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sd_qual_q <= 1'b0;
    else
      sd_qual_q <= sd_qual_d;
  end

  assign latch_set[`PSS_LT_RX_ERROR]      = phy_in.rx_error_evt;
  assign latch_clr[`PSS_LT_RX_ERROR]      = rd_hit.rx_error;
  assign latch_set[`PSS_LT_POLARITY]      = phy_in.polarity_inverted;
  assign latch_clr[`PSS_LT_POLARITY]      = rd_hit.ten_mbps;
  assign latch_set[`PSS_LT_FALSE_CARRIER] = phy_in.false_carrier_evt;
  assign latch_clr[`PSS_LT_FALSE_CARRIER] = rd_hit.false_carrier;
  assign latch_set[`PSS_LT_SD_LOW]        = ~sd_qual_q;
  assign latch_clr[`PSS_LT_SD_LOW]        = rd_hit.summary;
  assign latch_set[`PSS_LT_LOCK_LOW]      = ~phy_in.descrambler_lock;
  assign latch_clr[`PSS_LT_LOCK_LOW]      = rd_hit.summary;
  assign latch_set[`PSS_LT_PAGE_RCVD]     = phy_in.page_rcvd_evt;
  assign latch_clr[`PSS_LT_PAGE_RCVD]     = rd_hit.an_expansion;
  assign latch_set[`PSS_LT_INT_PENDING]   = phy_in.int_pending_evt;
  assign latch_clr[`PSS_LT_INT_PENDING]   = rd_hit.int_status;
  assign latch_set[`PSS_LT_REMOTE_FAULT]  = phy_in.remote_fault_evt;
  assign latch_clr[`PSS_LT_REMOTE_FAULT]  = rd_hit.basic_status;
  assign latch_set[`PSS_LT_JABBER]        = phy_in.jabber_detect;
  assign latch_clr[`PSS_LT_JABBER]        = rd_hit.basic_status;
  assign latch_set[`PSS_LT_LINK_LOW]      = ~phy_in.link_up;
  assign latch_clr[`PSS_LT_LINK_LOW]      = rd_hit.basic_status;

  genvar gi;
  generate
    for (gi = 0; gi < `PSS_NUM_LATCH; gi = gi + 1)
    begin : g_latch
      pss_sticky_bit u_bit (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_req (latch_set[gi]),
        .clr_req (latch_clr[gi]),
        .held_q  (latch_q[gi])
      );
    end
  endgenerate

  // Latch-low bits show the live level only if it has not dropped since the last read.
  always_comb
  begin
    summary_w = `PSS_WORD_ZERO;
    summary_w[`PSS_BIT_RESERVED]      = 1'b0;
    summary_w[`PSS_BIT_CROSSOVER]     = phy_in.crossover_state;
    summary_w[`PSS_BIT_RX_ERROR]      = latch_q[`PSS_LT_RX_ERROR];
    summary_w[`PSS_BIT_POLARITY]      = latch_q[`PSS_LT_POLARITY];
    summary_w[`PSS_BIT_FALSE_CARRIER] = latch_q[`PSS_LT_FALSE_CARRIER];
    summary_w[`PSS_BIT_SIG_DETECT]    = sd_qual_q & ~latch_q[`PSS_LT_SD_LOW];
    summary_w[`PSS_BIT_DESCR_LOCK]    = phy_in.descrambler_lock & ~latch_q[`PSS_LT_LOCK_LOW];
    summary_w[`PSS_BIT_PAGE_RCVD]     = latch_q[`PSS_LT_PAGE_RCVD];
    summary_w[`PSS_BIT_INT_PENDING]   = latch_q[`PSS_LT_INT_PENDING];
    summary_w[`PSS_BIT_REMOTE_FAULT]  = latch_q[`PSS_LT_REMOTE_FAULT];
    summary_w[`PSS_BIT_JABBER]        = latch_q[`PSS_LT_JABBER];
    summary_w[`PSS_BIT_AN_COMPLETE]   = phy_in.an_complete;
    summary_w[`PSS_BIT_LOOPBACK]      = phy_in.loopback_en;
    summary_w[`PSS_BIT_DUPLEX]        = phy_in.duplex_full;
    summary_w[`PSS_BIT_SPEED10]       = phy_in.speed_10;
    summary_w[`PSS_BIT_LINK]          = phy_in.link_up & ~latch_q[`PSS_LT_LINK_LOW];
  end

  // Keeps the checks off through the first edge after reset, whose samples still show reset state.
  always_ff @(posedge ref_clk)
  begin
    rst_q <= rst;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || rst_q);

  a_rxerr_set:
    assert property (phy_in.rx_error_evt |=> summary_w[`PSS_BIT_RX_ERROR])
    else $error("receive error latch did not set");

  a_rxerr_clear:
    assert property (rd_hit.rx_error && !phy_in.rx_error_evt |=> !summary_w[`PSS_BIT_RX_ERROR])
    else $error("receive error latch did not clear on counter read");

  a_rxerr_hold:
    assert property (summary_w[`PSS_BIT_RX_ERROR] && !rd_hit.rx_error |=> summary_w[`PSS_BIT_RX_ERROR])
    else $error("receive error latch dropped without counter read");

  a_polarity_keep:
    assert property (rd_hit.summary && summary_w[`PSS_BIT_POLARITY] |=> summary_w[`PSS_BIT_POLARITY])
    else $error("polarity bit cleared by summary read");

  a_polarity_set:
    assert property (phy_in.polarity_inverted |=> summary_w[`PSS_BIT_POLARITY])
    else $error("polarity bit did not follow inversion");

  a_polarity_clear:
    assert property (rd_hit.ten_mbps && !phy_in.polarity_inverted |=> !summary_w[`PSS_BIT_POLARITY])
    else $error("polarity bit not cleared by status read");

  a_fcar_hold:
    assert property (summary_w[`PSS_BIT_FALSE_CARRIER] && !rd_hit.false_carrier
                     |=> summary_w[`PSS_BIT_FALSE_CARRIER])
    else $error("false carrier latch dropped without counter read");

  a_fcar_set:
    assert property (phy_in.false_carrier_evt |=> summary_w[`PSS_BIT_FALSE_CARRIER])
    else $error("false carrier latch did not set");

  a_fcar_clear:
    assert property (rd_hit.false_carrier && !phy_in.false_carrier_evt |=> !summary_w[`PSS_BIT_FALSE_CARRIER])
    else $error("false carrier latch not cleared by counter read");

  a_sd_qualified:
    assert property (sd_qual_en && !phy_in.descrambler_lock |=> !sd_qual_q)
    else $error("qualified signal detect high without lock");

  a_sd_raw_only:
    assert property (!sd_qual_en && phy_in.signal_detect_raw |=> sd_qual_q)
    else $error("signal detect not raw while qualify is off");

  a_sd_qual_on:
    assert property (sd_qual_en && phy_in.descrambler_lock && phy_in.signal_detect_raw |=> sd_qual_q)
    else $error("qualified signal detect low with lock and raw detect");

  a_sd_raw_low:
    assert property (!phy_in.signal_detect_raw |=> !sd_qual_q)
    else $error("signal detect high without raw detect");

  a_sd_latch_low:
    assert property (!sd_qual_q ##1 sd_qual_q |-> !summary_w[`PSS_BIT_SIG_DETECT])
    else $error("signal detect drop not held low");

  a_sd_release:
    assert property (rd_hit.summary && sd_qual_q ##1 sd_qual_q |-> summary_w[`PSS_BIT_SIG_DETECT])
    else $error("signal detect not released by summary read");

  a_lock_latch_low:
    assert property (!phy_in.descrambler_lock && !rd_hit.summary ##1 phy_in.descrambler_lock
                     |-> !summary_w[`PSS_BIT_DESCR_LOCK])
    else $error("descrambler lock drop not held low");

  a_lock_release:
    assert property (rd_hit.summary && phy_in.descrambler_lock ##1 phy_in.descrambler_lock
                     |-> summary_w[`PSS_BIT_DESCR_LOCK])
    else $error("descrambler lock not released by summary read");

  a_page_keep:
    assert property (summary_w[`PSS_BIT_PAGE_RCVD] && !rd_hit.an_expansion |=> summary_w[`PSS_BIT_PAGE_RCVD])
    else $error("page received cleared without expansion read");

  a_page_set:
    assert property (phy_in.page_rcvd_evt |=> summary_w[`PSS_BIT_PAGE_RCVD])
    else $error("page received did not set");

  a_page_clear:
    assert property (rd_hit.an_expansion && !phy_in.page_rcvd_evt |=> !summary_w[`PSS_BIT_PAGE_RCVD])
    else $error("page received not cleared by expansion read");

  a_irq_clear:
    assert property (rd_hit.int_status && !phy_in.int_pending_evt |=> !summary_w[`PSS_BIT_INT_PENDING])
    else $error("interrupt pending not cleared by status read");

  a_irq_set:
    assert property (phy_in.int_pending_evt |=> summary_w[`PSS_BIT_INT_PENDING])
    else $error("interrupt pending did not set");

  a_irq_keep:
    assert property (summary_w[`PSS_BIT_INT_PENDING] && !rd_hit.int_status |=> summary_w[`PSS_BIT_INT_PENDING])
    else $error("interrupt pending dropped without status read");

  a_rfault_set:
    assert property (phy_in.remote_fault_evt |=> summary_w[`PSS_BIT_REMOTE_FAULT] ##1
                     (summary_w[`PSS_BIT_REMOTE_FAULT] || $past(rd_hit.basic_status)))
    else $error("remote fault did not set or hold");

  a_rfault_clear:
    assert property (rd_hit.basic_status && !phy_in.remote_fault_evt |=> !summary_w[`PSS_BIT_REMOTE_FAULT])
    else $error("remote fault not cleared by basic status read");

  a_jabber_keep:
    assert property (rd_hit.summary && summary_w[`PSS_BIT_JABBER] |=> summary_w[`PSS_BIT_JABBER])
    else $error("jabber cleared by summary read");

  a_jabber_set:
    assert property (phy_in.jabber_detect |=> summary_w[`PSS_BIT_JABBER])
    else $error("jabber bit did not follow detect");

  a_jabber_clear:
    assert property (rd_hit.basic_status && !phy_in.jabber_detect |=> !summary_w[`PSS_BIT_JABBER])
    else $error("jabber bit not cleared by basic status read");

  a_link_drop:
    assert property (!phy_in.link_up && !rd_hit.basic_status ##1 phy_in.link_up
                     |-> !summary_w[`PSS_BIT_LINK])
    else $error("link drop not held in summary");

  a_link_release:
    assert property (rd_hit.basic_status && phy_in.link_up ##1 phy_in.link_up |-> summary_w[`PSS_BIT_LINK])
    else $error("link not released by basic status read");

  a_read_data:
    assert property (rd_hit.summary |=> rd_data == $past(summary_w))
    else $error("summary read returned wrong word");

  a_reserved_zero:
    assert property (!rd_data[`PSS_BIT_RESERVED])
    else $error("reserved bit read as one");

  a_an_complete:
    assert property (rd_hit.summary |=> rd_data[`PSS_BIT_AN_COMPLETE] == $past(phy_in.an_complete))
    else $error("negotiation complete bit wrong in read data");

  a_loopback_mirror:
    assert property (rd_hit.summary |=> rd_data[`PSS_BIT_LOOPBACK] == $past(phy_in.loopback_en))
    else $error("loopback bit wrong in read data");

  a_duplex_mirror:
    assert property (rd_hit.summary |=> rd_data[`PSS_BIT_DUPLEX] == $past(phy_in.duplex_full))
    else $error("duplex bit wrong in read data");

  a_speed_mirror:
    assert property (rd_hit.summary |=> rd_data[`PSS_BIT_SPEED10] == $past(phy_in.speed_10))
    else $error("speed bit wrong in read data");

  a_crossover_mirror:
    assert property (rd_hit.summary |=> rd_data[`PSS_BIT_CROSSOVER] == $past(phy_in.crossover_state))
    else $error("crossover bit wrong in read data");

  a_write_ignored:
    assert property (bus_req.wr && !bus_req.rd && bus_req.addr == `PSS_OFF_SUMMARY && latch_set == '0
                     |=> latch_q == $past(latch_q))
    else $error("summary write disturbed a latch");

  a_write_no_cfg:
    assert property (bus_req.wr && bus_req.addr != `PSS_OFF_PCS_CONFIG |=> sd_qual_en == $past(sd_qual_en))
    else $error("write elsewhere changed the qualify enable");

endmodule // pss_status_summary

// ==== verilog/pss_defines.svh ====
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Management bus geometry.
`define PSS_ADDR_W            5
`define PSS_DATA_W            16

// Register offsets on the management bus.
`define PSS_OFF_BASIC_STATUS  5'h01
`define PSS_OFF_AN_EXPANSION  5'h06
`define PSS_OFF_SUMMARY       5'h10
`define PSS_OFF_INT_STATUS    5'h12
`define PSS_OFF_FALSE_CARRIER 5'h14
`define PSS_OFF_RX_ERROR      5'h15
`define PSS_OFF_PCS_CONFIG    5'h16
`define PSS_OFF_TEN_MBPS      5'h1A

// Field positions in the summary word.
`define PSS_BIT_RESERVED      15
`define PSS_BIT_CROSSOVER     14
`define PSS_BIT_RX_ERROR      13
`define PSS_BIT_POLARITY      12
`define PSS_BIT_SIG_DETECT    10
`define PSS_BIT_FALSE_CARRIER 11
`define PSS_BIT_DESCR_LOCK    9
`define PSS_BIT_PAGE_RCVD     8
`define PSS_BIT_INT_PENDING   7
`define PSS_BIT_REMOTE_FAULT  6
`define PSS_BIT_JABBER        5
`define PSS_BIT_AN_COMPLETE   4
`define PSS_BIT_LOOPBACK      3
`define PSS_BIT_DUPLEX        2
`define PSS_BIT_SPEED10       1
`define PSS_BIT_LINK          0

// Signal-detect qualify enable inside the configuration register.
`define PSS_BIT_SD_QUAL       8
`define PSS_SD_QUAL_RST       1'h0

// Latch slots held by the sticky-bit bank.
`define PSS_NUM_LATCH         10
`define PSS_LT_RX_ERROR       0
`define PSS_LT_POLARITY       1
`define PSS_LT_FALSE_CARRIER  2
`define PSS_LT_SD_LOW         3
`define PSS_LT_LOCK_LOW       4
`define PSS_LT_PAGE_RCVD      5
`define PSS_LT_INT_PENDING    6
`define PSS_LT_REMOTE_FAULT   7
`define PSS_LT_JABBER         8
`define PSS_LT_LINK_LOW       9

`define PSS_WORD_ZERO         16'h0000

`endif

// ==== verilog/pss_pkg.sv ====
package pss_pkg;
  `include "pss_defines.svh"

  // One management bus request as the master drives it.
  typedef struct packed {
    logic                   rd;
    logic                   wr;
    logic [`PSS_ADDR_W-1:0] addr;
    logic [`PSS_DATA_W-1:0] wdata;
  } pss_bus_req_t;

  // Raw indications from the physical-layer logic, same clock.
  typedef struct packed {
    logic rx_error_evt;
    logic polarity_inverted;
    logic false_carrier_evt;
    logic signal_detect_raw;
    logic descrambler_lock;
    logic page_rcvd_evt;
    logic int_pending_evt;
    logic remote_fault_evt;
    logic jabber_detect;
    logic an_complete;
    logic loopback_en;
    logic duplex_full;
    logic speed_10;
    logic link_up;
    logic crossover_state;
  } pss_phy_in_t;

  // One-cycle read hits on the registers whose reads clear latches.
  typedef struct packed {
    logic basic_status;
    logic an_expansion;
    logic summary;
    logic int_status;
    logic false_carrier;
    logic rx_error;
    logic ten_mbps;
  } pss_rd_hit_t;
endpackage

// ==== verilog/pss_sticky_bit.sv ====
`timescale 1ns/10ps
module pss_sticky_bit
  import pss_pkg::*;
(
  input  wire logic ref_clk, // System clock.
  input  wire logic rst,     // Synchronous reset, active high.
  input  wire logic set_req, // Event or level that sets the latch.
  input  wire logic clr_req, // Clearing read.
  output logic      held_q   // Latched state.
);

  // A set in the clearing cycle wins so no event is lost.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      held_q <= 1'b0;
    else if (set_req)
      held_q <= 1'b1;
    else if (clr_req)
      held_q <= 1'b0;
  end

endmodule // pss_sticky_bit

// ==== verilog/pss_reg_port.sv ====
`timescale 1ns/10ps
module pss_reg_port
  import pss_pkg::*;
(
  input  wire logic                   ref_clk,   // System clock.
  input  wire pss_bus_req_t           bus_req,   // Management bus request.
  input  wire logic                   rst,       // Synchronous reset, active high.
  input  wire logic [`PSS_DATA_W-1:0] summary_w, // Live summary word.
  output logic [`PSS_DATA_W-1:0]      rd_data,   // Read data, cycle after the read.
  output logic                        sd_qual_en, // Qualify signal detect with lock.
  output pss_rd_hit_t                 rd_hit     // Read hits per register.
);

  logic                   sd_qual_q;
  logic                   sd_qual_d;
  logic [`PSS_DATA_W-1:0] cfg_word;
  logic [`PSS_DATA_W-1:0] rd_mux;
  logic                   hit_summary;
  logic                   hit_cfg;
  logic                   rd_summary;
  logic                   rd_cfg;

  assign hit_summary = (bus_req.addr == `PSS_OFF_SUMMARY);
  assign hit_cfg     = (bus_req.addr == `PSS_OFF_PCS_CONFIG);
  assign rd_summary  = bus_req.rd & hit_summary;
  assign rd_cfg      = bus_req.rd & hit_cfg;

  assign rd_hit.basic_status  = bus_req.rd & (bus_req.addr == `PSS_OFF_BASIC_STATUS);
  assign rd_hit.an_expansion  = bus_req.rd & (bus_req.addr == `PSS_OFF_AN_EXPANSION);
  assign rd_hit.summary       = rd_summary;
  assign rd_hit.int_status    = bus_req.rd & (bus_req.addr == `PSS_OFF_INT_STATUS);
  assign rd_hit.false_carrier = bus_req.rd & (bus_req.addr == `PSS_OFF_FALSE_CARRIER);
  assign rd_hit.rx_error      = bus_req.rd & (bus_req.addr == `PSS_OFF_RX_ERROR);
  assign rd_hit.ten_mbps      = bus_req.rd & (bus_req.addr == `PSS_OFF_TEN_MBPS);

  // summary writes ignored
  // Only the qualify enable is writable; the summary word takes no writes.
  assign sd_qual_d = (bus_req.wr & hit_cfg) ? bus_req.wdata[`PSS_BIT_SD_QUAL] : sd_qual_q;
  assign sd_qual_en = sd_qual_q;

  always_comb
  begin
    cfg_word = `PSS_WORD_ZERO;
    cfg_word[`PSS_BIT_SD_QUAL] = sd_qual_q;
  end

  // Unmapped addresses read as zero.
  assign rd_mux = rd_summary ? summary_w : (rd_cfg ? cfg_word : `PSS_WORD_ZERO);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sd_qual_q <= `PSS_SD_QUAL_RST;
      rd_data   <= `PSS_WORD_ZERO;
    end
    else
    begin
      sd_qual_q <= sd_qual_d;
      rd_data   <= bus_req.rd ? rd_mux : `PSS_WORD_ZERO;
    end
  end

endmodule // pss_reg_port

// ==== sim/pss_host_model.sv ====
`timescale 1ns/10ps
`include "pss_defines.svh"
module pss_host_model
  import pss_pkg::*;
(
  input  wire logic                   ref_clk, // System clock.
  output pss_bus_req_t                bus_req, // Request to the block.
  input  wire logic [`PSS_DATA_W-1:0] rd_data  // Read data from the block.
);
  initial bus_req = '0;

  // Single-cycle write; the block never makes the host wait.
  task automatic wr(input logic [`PSS_ADDR_W-1:0] a, input logic [`PSS_DATA_W-1:0] d);
    @(posedge ref_clk);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask

  // Read data is taken in the only cycle in which it stands.
  task automatic rd(input logic [`PSS_ADDR_W-1:0] a, output logic [`PSS_DATA_W-1:0] d);
    @(posedge ref_clk);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 d = rd_data;
  endtask
endmodule // pss_host_model

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`include "pss_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb
  import pss_pkg::*;
;
  typedef struct packed {
    pss_phy_in_t in;
    logic [15:0] exp;
  } pss_lvl_row_t;

  typedef struct packed {
    pss_phy_in_t ev;
    logic [4:0]  clr;
    logic [15:0] mask;
  } pss_evt_row_t;

  localparam pss_phy_in_t base_in = '{signal_detect_raw: 1'b1, descrambler_lock: 1'b1, link_up: 1'b1, default: 1'b0};
  localparam logic [15:0] base_word = 16'h0601;

  logic                   ref_clk;
  logic                   rst;
  pss_bus_req_t           bus_req;
  logic [`PSS_DATA_W-1:0] rd_data;
  pss_phy_in_t            phy;
  logic                   sd_qual_q;
  logic [`PSS_DATA_W-1:0] got;
  int                     n_fail = 0;
  int                     comparisons = 0;

  pss_lvl_row_t lvl_rows [6] = '{
    '{'{an_complete: 1'b1, default: 1'b0}, 16'h0010},
    '{'{loopback_en: 1'b1, default: 1'b0}, 16'h0008},
    '{'{duplex_full: 1'b1, default: 1'b0}, 16'h0004},
    '{'{speed_10: 1'b1, default: 1'b0}, 16'h0002},
    '{'{crossover_state: 1'b1, default: 1'b0}, 16'h4000},
    '{'{an_complete: 1'b1, loopback_en: 1'b1, duplex_full: 1'b1, speed_10: 1'b1, crossover_state: 1'b1,
        default: 1'b0}, 16'h401E}
  };

  pss_evt_row_t evt_rows [7] = '{
    '{'{rx_error_evt: 1'b1, default: 1'b0}, `PSS_OFF_RX_ERROR, 16'h2000},
    '{'{polarity_inverted: 1'b1, default: 1'b0}, `PSS_OFF_TEN_MBPS, 16'h1000},
    '{'{false_carrier_evt: 1'b1, default: 1'b0}, `PSS_OFF_FALSE_CARRIER, 16'h0800},
    '{'{page_rcvd_evt: 1'b1, default: 1'b0}, `PSS_OFF_AN_EXPANSION, 16'h0100},
    '{'{int_pending_evt: 1'b1, default: 1'b0}, `PSS_OFF_INT_STATUS, 16'h0080},
    '{'{remote_fault_evt: 1'b1, default: 1'b0}, `PSS_OFF_BASIC_STATUS, 16'h0040},
    '{'{jabber_detect: 1'b1, default: 1'b0}, `PSS_OFF_BASIC_STATUS, 16'h0020}
  };

  pss_status_summary DUT (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .bus_req   (bus_req),
    .rd_data   (rd_data),
    .phy_in    (phy),
    .sd_qual_q (sd_qual_q)
  );

  pss_host_model host (
    .ref_clk (ref_clk),
    .bus_req (bus_req),
    .rd_data (rd_data)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  task automatic chk(input logic [4:0] a, input logic [15:0] e);
    host.rd(a, got);
    `CHK(got, e)
  endtask

  // Releases the latched-low bits so that they follow the live levels.
  task automatic prime();
    host.rd(`PSS_OFF_BASIC_STATUS, got);
    host.rd(`PSS_OFF_SUMMARY, got);
  endtask

  task automatic pulse(input pss_phy_in_t m);
    @(posedge ref_clk);
    phy <= pss_phy_in_t'(phy | m);
    @(posedge ref_clk);
    phy <= pss_phy_in_t'(phy & ~m);
    repeat (2) @(posedge ref_clk);
  endtask

  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end

  initial
  begin
    rst = 1'b1;
    phy = base_in;
    do_reset();
    prime();
    foreach (lvl_rows[i])
    begin
      @(posedge ref_clk) phy <= pss_phy_in_t'(base_in | lvl_rows[i].in);
      repeat (2) @(posedge ref_clk);
      chk(`PSS_OFF_SUMMARY, base_word | lvl_rows[i].exp);
    end
    @(posedge ref_clk) phy <= base_in;
    foreach (evt_rows[i])
    begin
      pulse(evt_rows[i].ev);
      chk(`PSS_OFF_SUMMARY, base_word | evt_rows[i].mask);
      chk(`PSS_OFF_SUMMARY, base_word | evt_rows[i].mask);
      host.rd(evt_rows[i].clr, got);
      chk(`PSS_OFF_SUMMARY, base_word);
    end
    // writes ignored, with a latch set meanwhile.
    pulse('{rx_error_evt: 1'b1, default: 1'b0});
    host.wr(`PSS_OFF_SUMMARY, 16'hFFFF);
    host.wr(5'h1F, 16'hFFFF);
    chk(5'h1F, 16'h0000);
    chk(`PSS_OFF_PCS_CONFIG, 16'h0000);
    chk(`PSS_OFF_SUMMARY, base_word | 16'h2000);
    host.rd(`PSS_OFF_RX_ERROR, got);
    chk(`PSS_OFF_SUMMARY, base_word);
    host.wr(`PSS_OFF_PCS_CONFIG, 16'h0100);
    chk(`PSS_OFF_PCS_CONFIG, 16'h0100);
    #1 `CHK(sd_qual_q, 1'b1)
    @(posedge ref_clk) phy.descrambler_lock <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(sd_qual_q, 1'b0)
    host.wr(`PSS_OFF_PCS_CONFIG, 16'h0000);
    repeat (3) @(posedge ref_clk);
    #1 `CHK(sd_qual_q, 1'b1)
    @(posedge ref_clk) phy.descrambler_lock <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(`PSS_OFF_SUMMARY, 16'h0001);
    chk(`PSS_OFF_SUMMARY, base_word);
    // raw detect drop with qualify off, held low until read.
    @(posedge ref_clk) phy.signal_detect_raw <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(sd_qual_q, 1'b0)
    @(posedge ref_clk) phy.signal_detect_raw <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(`PSS_OFF_SUMMARY, 16'h0201);
    chk(`PSS_OFF_SUMMARY, base_word);
    @(posedge ref_clk) phy.link_up <= 1'b0;
    @(posedge ref_clk) phy.link_up <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(`PSS_OFF_SUMMARY, 16'h0600);
    chk(`PSS_OFF_SUMMARY, 16'h0600);
    host.rd(`PSS_OFF_BASIC_STATUS, got);
    chk(`PSS_OFF_SUMMARY, base_word);
    pulse('{remote_fault_evt: 1'b1, default: 1'b0});
    do_reset();
    chk(`PSS_OFF_SUMMARY, 16'h0201);
    chk(`PSS_OFF_SUMMARY, base_word);
    final_report();
  end
endmodule // tb
